//--- logic/ilsb_pkg.sv
// ilsb_pkg: constants and carrier types for the transmit rate limiter
// and diagnostic sideband block; assumes a 32-bit AXI4-Lite register bus
package ilsb_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ILSB_REG_CTRL = 8'h00;
  localparam logic [7:0] ILSB_REG_BUCKET_MAX = 8'h04;
  localparam logic [7:0] ILSB_REG_REFILL_AMT = 8'h08;
  localparam logic [7:0] ILSB_REG_REFILL_PER = 8'h0C;
  localparam logic [7:0] ILSB_REG_BURST_MAX = 8'h10;
  localparam logic [7:0] ILSB_REG_TOKENS = 8'h14;
  localparam logic [7:0] ILSB_REG_CRC_OK = 8'h18;
  localparam logic [7:0] ILSB_REG_RX_MUBITS = 8'h1C;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int ILSB_CTRL_ENABLE_BIT = 0;
  localparam logic [11:0] ILSB_BUCKET_MAX_RST = 12'h100;
  localparam logic [11:0] ILSB_REFILL_AMT_RST = 12'h0A0;
  localparam logic [7:0] ILSB_REFILL_PER_RST = 8'h10;
  localparam logic [11:0] ILSB_BURST_MAX_RST = 12'h100;

  // ----------------------------------------
  // word layout
  // ----------------------------------------
  localparam int ILSB_DIAG_INTF_BIT = 32;
  localparam int ILSB_DIAG_LANE_BIT = 33;
  localparam int ILSB_MU_LSB = 24;
  localparam int ILSB_MU_W = 8;
  localparam int ILSB_TOK_W = 16;
  localparam logic [15:0] ILSB_TOKENS_PER_WORD = 16'h0008;

  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  localparam logic [1:0] ILSB_RESP_OKAY = 2'h0;
  localparam logic [1:0] ILSB_RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } ilsb_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ilsb_axil_rsp_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [63:0] data;
  } ilsb_word_t;

  typedef struct packed {
    logic valid;
    logic crc_good;
    logic [63:0] word;
  } ilsb_diag_rx_t;

endpackage

//--- logic/ilsb_sideband.sv
// ilsb_sideband: transmit token-bucket rate limiter, per-lane diagnostic
// word status, health bit insertion and multi-use bit insertion/extraction.
// assumes framing, lane lock and CRC32 computation happen outside; this
// block sees finished words one per clock on each path.
//
// Summary of operation
// - when enabled, idle control words are inserted between data segments
// - burst starts only with at least burst-max tokens; one token per byte
// - token count may go negative to finish a burst in progress
// - every refill-period plus one cycles, refill-amount tokens are added
// - eight tokens drained per data word forwarded, even short end words
// - enable bit 1 turns the limiter on, 0 turns it off
// - bucket never exceeds capacity; capacity programmed at least burst-max
// - crc ok is 1 only while locked and latest diagnostic CRC good
// - crc fault pulses one cycle per mismatch seen while locked
// - CRC mismatch is status only, lock untouched
// - only CRC checked; diagnostic bits 57:34 ignored
// - received interface health follows bit 32 of latest diagnostic word
// - received lane health follows bit 33 of latest diagnostic word
// - transmit interface health input goes into bit 32 on all lanes
// - each lane health input goes into bit 33 of that lane
// - multi-use input copied into control word bits 31:24, bit 0 at 24
// - look-aside mode has no multi-use input insertion
// - received control word bits 31:24 drive the multi-use output
// - link errors leave the received multi-use output unchanged
// - all-aligned status is 1 when all lanes aligned and deskew done
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module ilsb_sideband #(
  parameter int LANES = 4,
  parameter bit LOOK_ASIDE = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire ilsb_pkg::ilsb_axil_req_t axil_req,
  output ilsb_pkg::ilsb_axil_rsp_t axil_rsp,
  // transmit data words
  input wire ilsb_pkg::ilsb_word_t tx_data_in,
  output logic tx_data_ready,
  output ilsb_pkg::ilsb_word_t tx_data_out,
  output logic tx_idle_insert,
  // transmit control and diagnostic words
  input wire ilsb_pkg::ilsb_word_t tx_ctl_in,
  input wire logic [7:0] tx_mubits,
  output ilsb_pkg::ilsb_word_t tx_ctl_out,
  input wire ilsb_pkg::ilsb_word_t [LANES-1:0] tx_diag_in,
  input wire logic tx_diag_intf_health,
  input wire logic [LANES-1:0] tx_diag_lane_health,
  output ilsb_pkg::ilsb_word_t [LANES-1:0] tx_diag_out,
  // receive diagnostic words
  input wire logic [LANES-1:0] rx_lane_locked,
  input wire ilsb_pkg::ilsb_diag_rx_t [LANES-1:0] rx_diag_in,
  output logic [LANES-1:0] lane_diag_crc_ok,
  output logic [LANES-1:0] lane_diag_crc_fault,
  output logic [LANES-1:0] rx_diag_intf_health,
  output logic [LANES-1:0] rx_diag_lane_health,
  // receive control words and alignment
  input wire ilsb_pkg::ilsb_word_t rx_ctl_in,
  input wire logic rx_link_err,
  output logic [7:0] rx_mubits,
  input wire logic [LANES-1:0] rx_lane_aligned,
  input wire logic rx_deskew_done,
  output logic rx_all_aligned
);
  import ilsb_pkg::*;

  typedef struct packed {
    logic aw_hold;
    logic [7:0] aw_addr;
    logic w_hold;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic enable;
    logic [11:0] bucket_max;
    logic [11:0] refill_amt;
    logic [7:0] refill_per;
    logic [11:0] burst_max;
    logic signed [ILSB_TOK_W-1:0] tokens;
    logic [7:0] refill_cnt;
    logic in_burst;
    ilsb_word_t data_out;
    logic idle;
    ilsb_word_t ctl_out;
    ilsb_word_t [LANES-1:0] diag_out;
    logic [LANES-1:0] crc_ok;
    logic [LANES-1:0] crc_fault;
    logic [LANES-1:0] intf;
    logic [LANES-1:0] lanest;
    logic [7:0] mubits;
    logic aligned;
  } ilsb_state_t;

  ilsb_state_t st;
  ilsb_state_t next_st;

  logic gate_open;
  logic take_word;
  logic signed [ILSB_TOK_W+1:0] tok_sum;
  logic signed [ILSB_TOK_W+1:0] tok_cap;
  logic [31:0] wr_merge;
  logic [31:0] rd_word;
  logic rd_hit;
  logic wr_hit;

  // ----------------------------------------
  // handshake outputs
  // ----------------------------------------
  // limiter gate: off passes all; a started burst may not be cut
  assign gate_open = !st.enable || st.in_burst ||
    (st.tokens >= $signed({4'h0, st.burst_max}));
  assign tx_data_ready = gate_open;
  assign take_word = tx_data_in.valid && gate_open;

  always_comb begin
    axil_rsp.awready = !st.aw_hold && !st.bvalid;
    axil_rsp.wready = !st.w_hold && !st.bvalid;
    axil_rsp.bvalid = st.bvalid;
    axil_rsp.bresp = st.bresp;
    axil_rsp.arready = !st.rvalid;
    axil_rsp.rvalid = st.rvalid;
    axil_rsp.rdata = st.rdata;
    axil_rsp.rresp = st.rresp;
  end

  // ----------------------------------------
  // register read mux and write merge
  // ----------------------------------------
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (axil_req.araddr)
      ILSB_REG_CTRL: rd_word[ILSB_CTRL_ENABLE_BIT] = st.enable;
      ILSB_REG_BUCKET_MAX: rd_word[11:0] = st.bucket_max;
      ILSB_REG_REFILL_AMT: rd_word[11:0] = st.refill_amt;
      ILSB_REG_REFILL_PER: rd_word[7:0] = st.refill_per;
      ILSB_REG_BURST_MAX: rd_word[11:0] = st.burst_max;
      ILSB_REG_TOKENS: rd_word = {{(32-ILSB_TOK_W){st.tokens[ILSB_TOK_W-1]}}, st.tokens};
      ILSB_REG_CRC_OK: rd_word[LANES-1:0] = st.crc_ok;
      ILSB_REG_RX_MUBITS: rd_word[7:0] = st.mubits;
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_merge = 32'h0000_0000;
    wr_hit = 1'b1;
    case (st.aw_addr)
      ILSB_REG_CTRL: wr_merge[ILSB_CTRL_ENABLE_BIT] = st.enable;
      ILSB_REG_BUCKET_MAX: wr_merge[11:0] = st.bucket_max;
      ILSB_REG_REFILL_AMT: wr_merge[11:0] = st.refill_amt;
      ILSB_REG_REFILL_PER: wr_merge[7:0] = st.refill_per;
      ILSB_REG_BURST_MAX: wr_merge[11:0] = st.burst_max;
      ILSB_REG_TOKENS, ILSB_REG_CRC_OK, ILSB_REG_RX_MUBITS: wr_merge = 32'h0000_0000;
      default: wr_hit = 1'b0;
    endcase
    for (int b = 0; b < 4; b++) begin
      if (st.w_strb[b]) begin
        wr_merge[b*8 +: 8] = st.w_data[b*8 +: 8];
      end
    end
  end

  // ----------------------------------------
  // token arithmetic
  // ----------------------------------------
  always_comb begin
    tok_sum = {{2{st.tokens[ILSB_TOK_W-1]}}, st.tokens};
    if (st.refill_cnt == 8'h00) begin
      tok_sum = tok_sum + $signed({6'h00, st.refill_amt});
    end
    if (take_word) begin
      tok_sum = tok_sum - $signed({2'h0, ILSB_TOKENS_PER_WORD});
    end
    tok_cap = $signed({6'h00, st.bucket_max});
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;

    // write channel: address and data taken in either order
    if (axil_req.awvalid && axil_rsp.awready) begin
      next_st.aw_hold = 1'b1;
      next_st.aw_addr = axil_req.awaddr;
    end
    if (axil_req.wvalid && axil_rsp.wready) begin
      next_st.w_hold = 1'b1;
      next_st.w_data = axil_req.wdata;
      next_st.w_strb = axil_req.wstrb;
    end
    if (st.bvalid && axil_req.bready) begin
      next_st.bvalid = 1'b0;
    end
    if (st.aw_hold && st.w_hold) begin
      next_st.aw_hold = 1'b0;
      next_st.w_hold = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = wr_hit ? ILSB_RESP_OKAY : ILSB_RESP_SLVERR;
      case (st.aw_addr)
        ILSB_REG_CTRL: next_st.enable = wr_merge[ILSB_CTRL_ENABLE_BIT];
        ILSB_REG_BUCKET_MAX: next_st.bucket_max = wr_merge[11:0];
        ILSB_REG_REFILL_AMT: next_st.refill_amt = wr_merge[11:0];
        ILSB_REG_REFILL_PER: next_st.refill_per = wr_merge[7:0];
        ILSB_REG_BURST_MAX: next_st.burst_max = wr_merge[11:0];
        default: next_st.enable = st.enable;
      endcase
    end

    // read channel
    if (st.rvalid && axil_req.rready) begin
      next_st.rvalid = 1'b0;
    end
    if (axil_req.arvalid && axil_rsp.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = rd_word;
      next_st.rresp = rd_hit ? ILSB_RESP_OKAY : ILSB_RESP_SLVERR;
    end

    // token bucket: empty and idle while off, counts while on
    if (!st.enable) begin
      next_st.tokens = '0;
      next_st.refill_cnt = st.refill_per;
      next_st.in_burst = 1'b0;
    end else begin
      next_st.refill_cnt = (st.refill_cnt == 8'h00) ? st.refill_per : st.refill_cnt - 8'h01;
      if (tok_sum > tok_cap) begin
        next_st.tokens = tok_cap[ILSB_TOK_W-1:0];
      end else begin
        next_st.tokens = tok_sum[ILSB_TOK_W-1:0];
      end
      if (take_word) begin
        next_st.in_burst = !tx_data_in.last;
      end
    end

    // forwarded data and idle slot marker
    next_st.data_out.valid = take_word;
    next_st.data_out.last = take_word && tx_data_in.last;
    if (take_word) begin
      next_st.data_out.data = tx_data_in.data;
    end
    next_st.idle = st.enable && tx_data_in.valid && !gate_open;

    // transmit control word with multi-use field
    next_st.ctl_out.valid = tx_ctl_in.valid;
    next_st.ctl_out.last = tx_ctl_in.last;
    if (tx_ctl_in.valid) begin
      next_st.ctl_out.data = tx_ctl_in.data;
      if (!LOOK_ASIDE) begin
        next_st.ctl_out.data[ILSB_MU_LSB +: ILSB_MU_W] = tx_mubits;
      end
    end

    // receive control word multi-use field, frozen across link errors
    if (rx_ctl_in.valid && !rx_link_err) begin
      next_st.mubits = rx_ctl_in.data[ILSB_MU_LSB +: ILSB_MU_W];
    end

    next_st.aligned = (&rx_lane_aligned) && rx_deskew_done;

    // per-lane diagnostic words
    for (int l = 0; l < LANES; l++) begin
      next_st.diag_out[l].valid = tx_diag_in[l].valid;
      next_st.diag_out[l].last = tx_diag_in[l].last;
      if (tx_diag_in[l].valid) begin
        next_st.diag_out[l].data = tx_diag_in[l].data;
        next_st.diag_out[l].data[ILSB_DIAG_INTF_BIT] = tx_diag_intf_health;
        next_st.diag_out[l].data[ILSB_DIAG_LANE_BIT] = tx_diag_lane_health[l];
      end
      // only the CRC verdict matters; reserved bits are not looked at
      next_st.crc_fault[l] = rx_lane_locked[l] && rx_diag_in[l].valid &&
        !rx_diag_in[l].crc_good;
      if (!rx_lane_locked[l]) begin
        next_st.crc_ok[l] = 1'b0;
      end else if (rx_diag_in[l].valid) begin
        next_st.crc_ok[l] = rx_diag_in[l].crc_good;
      end
      if (rx_diag_in[l].valid) begin
        next_st.intf[l] = rx_diag_in[l].word[ILSB_DIAG_INTF_BIT];
        next_st.lanest[l] = rx_diag_in[l].word[ILSB_DIAG_LANE_BIT];
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.bucket_max <= ILSB_BUCKET_MAX_RST;
      st.refill_amt <= ILSB_REFILL_AMT_RST;
      st.refill_per <= ILSB_REFILL_PER_RST;
      st.burst_max <= ILSB_BURST_MAX_RST;
      st.refill_cnt <= ILSB_REFILL_PER_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  assign tx_data_out = st.data_out;
  assign tx_idle_insert = st.idle;
  assign tx_ctl_out = st.ctl_out;
  assign tx_diag_out = st.diag_out;
  assign lane_diag_crc_ok = st.crc_ok;
  assign lane_diag_crc_fault = st.crc_fault;
  assign rx_diag_intf_health = st.intf;
  assign rx_diag_lane_health = st.lanest;
  assign rx_mubits = st.mubits;
  assign rx_all_aligned = st.aligned;

endmodule

//--- testbench/ilsb_checker.sv
// ilsb_checker: port-level assertions for ilsb_sideband
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/1ns
module ilsb_checker #(
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // transmit side
  input wire ilsb_pkg::ilsb_word_t tx_data_in,
  input wire logic tx_data_ready,
  input wire ilsb_pkg::ilsb_word_t tx_data_out,
  input wire logic tx_idle_insert,
  input wire logic [7:0] tx_mubits,
  input wire ilsb_pkg::ilsb_word_t tx_ctl_out,
  input wire logic tx_diag_intf_health,
  input wire logic [LANES-1:0] tx_diag_lane_health,
  input wire ilsb_pkg::ilsb_word_t [LANES-1:0] tx_diag_out,
  // receive side
  input wire logic [LANES-1:0] rx_lane_locked,
  input wire ilsb_pkg::ilsb_diag_rx_t [LANES-1:0] rx_diag_in,
  input wire logic [LANES-1:0] lane_diag_crc_ok,
  input wire logic [LANES-1:0] lane_diag_crc_fault,
  input wire logic [LANES-1:0] rx_diag_intf_health,
  input wire logic [LANES-1:0] rx_diag_lane_health,
  input wire ilsb_pkg::ilsb_word_t rx_ctl_in,
  input wire logic rx_link_err,
  input wire logic [7:0] rx_mubits
);
  import ilsb_pkg::*;
  logic [LANES-1:0] bad_l;
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      bad_l[i] = rx_diag_in[i].valid && !rx_diag_in[i].crc_good && rx_lane_locked[i];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_take; tx_data_in.valid && tx_data_ready; endsequence
  sequence s_held; tx_data_in.valid && !tx_data_ready; endsequence
  data_pass_a: assert property (s_take |=> tx_data_out.valid && tx_data_out.data == $past(tx_data_in.data))
    else $error("taken word not forwarded");
  idle_slot_a: assert property (s_held |=> tx_idle_insert)
    else $error("held word without idle");
  fault_pulse_a: assert property (lane_diag_crc_fault == $past(bad_l))
    else $error("crc fault pulse wrong");
  ok_lock_a: assert property ((lane_diag_crc_ok & ~$past(rx_lane_locked)) == '0)
    else $error("crc ok while unlocked");
  ok_follow_a: assert property (rx_diag_in[1].valid && rx_lane_locked[1]
    |=> lane_diag_crc_ok[1] == $past(rx_diag_in[1].crc_good))
    else $error("crc ok not following");
  rx_health_a: assert property (rx_diag_in[1].valid |=> rx_diag_intf_health[1] ==
    $past(rx_diag_in[1].word[32]) && rx_diag_lane_health[1] == $past(rx_diag_in[1].word[33]))
    else $error("rx health bits wrong");
  tx_health_a: assert property (tx_diag_out[2].valid |-> tx_diag_out[2].data[32] ==
    $past(tx_diag_intf_health) && tx_diag_out[2].data[33] == $past(tx_diag_lane_health[2]))
    else $error("tx health bits wrong");
  tx_mu_a: assert property (tx_ctl_out.valid |-> tx_ctl_out.data[31:24] == $past(tx_mubits))
    else $error("tx multi-use wrong");
  rx_mu_a: assert property (rx_ctl_in.valid && !rx_link_err |=> rx_mubits == $past(rx_ctl_in.data[31:24]))
    else $error("rx multi-use wrong");
  mu_hold_a: assert property (rx_link_err |=> $stable(rx_mubits))
    else $error("rx multi-use moved on error");
endmodule
bind ilsb_sideband ilsb_checker #(.LANES(LANES)) chk_u (.*);

//--- testbench/ilsb_far_end.sv
// ilsb_far_end: remote device looping words back over the lanes
// assumes the bench commands which lanes see a bad CRC32
`timescale 1ns/1ns
module ilsb_far_end #(
  parameter int LANES = 4
) (
  // clock
  input wire logic aclk,
  // words from the block and fault command
  input wire ilsb_pkg::ilsb_word_t tx_ctl_out,
  input wire ilsb_pkg::ilsb_word_t [LANES-1:0] tx_diag_out,
  input wire logic [LANES-1:0] bad_crc,
  // words to the block
  output ilsb_pkg::ilsb_word_t rx_ctl_in,
  output ilsb_pkg::ilsb_diag_rx_t [LANES-1:0] rx_diag_in
);
  import ilsb_pkg::*;
  initial begin
    rx_ctl_in = '0;
    rx_diag_in = '0;
  end
  // idle lanes carry a toggling pattern, never the last word
  always @(posedge aclk) begin
    rx_ctl_in.valid <= tx_ctl_out.valid;
    rx_ctl_in.data <= tx_ctl_out.valid ? tx_ctl_out.data : ~rx_ctl_in.data;
    for (int i = 0; i < LANES; i++) begin
      rx_diag_in[i].valid <= tx_diag_out[i].valid;
      rx_diag_in[i].crc_good <= !bad_crc[i];
      rx_diag_in[i].word <= tx_diag_out[i].valid ? tx_diag_out[i].data : ~rx_diag_in[i].word;
    end
  end
endmodule

//--- testbench/ilsb_sideband_test.sv
// ilsb_sideband_test: self-checking bench for ilsb_sideband
// assumes the far-end model loops lane words back
`timescale 1ns/1ns
module ilsb_sideband_test;
  import ilsb_pkg::*;
  localparam int LANES = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  ilsb_axil_req_t req = '0;
  ilsb_axil_rsp_t rsp;
  ilsb_word_t tx_in = '0, tx_out, ctl_in = '0, ctl_out, rx_ctl;
  ilsb_word_t [LANES-1:0] dg_in = '0, dg_out;
  ilsb_diag_rx_t [LANES-1:0] rx_dg;
  logic rdy, idle, all_al, ihl = 1'b0, lerr = 1'b0, dsk = 1'b0;
  logic [7:0] mu = '0, rmu;
  logic [LANES-1:0] lhl = '0, lck = '0, bad = '0, al = '0, ok, flt, rih, rlh;
  logic [31:0] rd;
  logic [1:0] rr;
  int failures = 0, n_compared = 0, cyc = 0, n_out = 0, n_idle = 0, n_flt = 0;
  ilsb_sideband #(.LANES(LANES)) dut_u (.aclk(aclk), .aresetn(aresetn), .axil_req(req),
    .axil_rsp(rsp), .tx_data_in(tx_in), .tx_data_ready(rdy), .tx_data_out(tx_out),
    .tx_idle_insert(idle), .tx_ctl_in(ctl_in), .tx_mubits(mu), .tx_ctl_out(ctl_out),
    .tx_diag_in(dg_in), .tx_diag_intf_health(ihl), .tx_diag_lane_health(lhl),
    .tx_diag_out(dg_out), .rx_lane_locked(lck), .rx_diag_in(rx_dg), .lane_diag_crc_ok(ok),
    .lane_diag_crc_fault(flt), .rx_diag_intf_health(rih), .rx_diag_lane_health(rlh),
    .rx_ctl_in(rx_ctl), .rx_link_err(lerr), .rx_mubits(rmu), .rx_lane_aligned(al),
    .rx_deskew_done(dsk), .rx_all_aligned(all_al));
  ilsb_far_end #(.LANES(LANES)) far_u (.aclk(aclk), .tx_ctl_out(ctl_out), .tx_diag_out(dg_out),
    .bad_crc(bad), .rx_ctl_in(rx_ctl), .rx_diag_in(rx_dg));
  initial begin
    forever #25 aclk = ~aclk;
  end
  always @(negedge aclk) begin
    n_out += int'(tx_out.valid === 1'b1);
    n_idle += int'(idle === 1'b1);
    n_flt += int'(flt[2] === 1'b1);
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_of_test();
    end
  end
  // ----
  // shared tasks
  // ----
  task automatic end_of_test();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic c, input string m);
    n_compared++;
    if (c !== 1'b1) begin
      failures++;
      $display("Error %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    req.awaddr <= a;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    do begin
      @(negedge aclk);
      aw = req.awvalid & rsp.awready;
      w = req.wvalid & rsp.wready;
      b = rsp.bvalid;
      r = rsp.bresp;
      @(posedge aclk);
      if (aw) req.awvalid <= 1'b0;
      if (w) req.wvalid <= 1'b0;
    end while (b !== 1'b1);
    // bready stays high between writes so a following call never re-drives it in one step
  endtask
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, v;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar = req.arvalid & rsp.arready;
      v = rsp.rvalid;
      d = rsp.rdata;
      r = rsp.rresp;
      @(posedge aclk);
      if (ar) req.arvalid <= 1'b0;
    end while (v !== 1'b1);
    // rready stays high between reads so a following call never re-drives it in one step
  endtask
  // offers n words back to back, last closing every bl words; returns cycles taken
  task automatic offer(input int n, input int bl, output int el);
    time t0;
    t0 = $time;
    for (int k = 0; k < n; k++) begin
      tx_in <= '{valid: 1'b1, last: (k % bl == bl - 1), data: 64'(k)};
      do @(negedge aclk); while (rdy !== 1'b1);
      @(posedge aclk);
    end
    tx_in.valid <= 1'b0;
    el = int'(($time - t0) / 50);
    repeat (2) @(posedge aclk);
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_regs();
    rdr(ILSB_REG_BUCKET_MAX, rd, rr);
    chk(rd === {20'h0, ILSB_BUCKET_MAX_RST}, "capacity reset");
    rdr(ILSB_REG_REFILL_PER, rd, rr);
    chk(rd === {24'h0, ILSB_REFILL_PER_RST}, "period reset");
    rdr(ILSB_REG_TOKENS, rd, rr);
    chk(rd === 32'h0, "bucket not empty");
    rdr(8'h20, rd, rr);
    chk(rr === ILSB_RESP_SLVERR && rd === 32'h0, "unmapped read");
    wr(8'h24, 32'h1, rr);
    chk(rr === ILSB_RESP_SLVERR, "unmapped write");
    $display("test regs done");
  endtask
  task automatic t_lim();
    int el, i0;
    wr(ILSB_REG_BURST_MAX, 32'h10, rr);
    wr(ILSB_REG_BUCKET_MAX, 32'h20, rr);
    wr(ILSB_REG_REFILL_AMT, 32'h8, rr);
    wr(ILSB_REG_REFILL_PER, 32'h8, rr);
    wr(ILSB_REG_CTRL, 32'h1, rr);
    repeat (60) @(posedge aclk);
    rdr(ILSB_REG_TOKENS, rd, rr);
    chk(rd === 32'h20, "bucket not clamped at capacity");
    offer(8, 8, el);
    chk(el == 8, "burst interrupted");
    rdr(ILSB_REG_TOKENS, rd, rr);
    chk(rd[15] === 1'b1, "tokens not below zero");
    i0 = n_idle;
    offer(20, 2, el);
    chk(el >= 150 && el <= 250, "limited rate off");
    chk(n_idle - i0 == el - 20, "idle count");
    $display("test limiter done");
  endtask
  task automatic t_off();
    int el, o, i0;
    wr(ILSB_REG_CTRL, 32'h0, rr);
    o = n_out;
    i0 = n_idle;
    offer(16, 4, el);
    chk(el == 16 && n_out - o == 16 && n_idle == i0, "full rate when off");
    rdr(ILSB_REG_TOKENS, rd, rr);
    chk(rd === 32'h0, "bucket kept while off");
    $display("test off done");
  endtask
  task automatic t_diag();
    int f0;
    f0 = n_flt;
    lck <= 4'b1110;
    lhl <= 4'b1110;
    ihl <= 1'b1;
    bad <= 4'b0100;
    al <= 4'hF;
    dsk <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      dg_in <= {LANES{ilsb_word_t'{1'b1, 1'b0, 64'h03FF_FFFC_0000_0000}}};
      @(posedge aclk);
      dg_in <= '0;
      @(posedge aclk);
    end
    repeat (4) @(posedge aclk);
    chk(ok === 4'b1010, "crc ok");
    chk(rih === 4'hF && rlh === 4'b1110, "health bits");
    chk(n_flt - f0 == 3, "fault pulses");
    chk(all_al === 1'b1, "not aligned");
    al <= 4'b0111;
    lck <= 4'b0110;
    repeat (2) @(posedge aclk);
    chk(all_al === 1'b0 && ok === 4'b0010, "loss not seen");
    $display("test diag done");
  endtask
  task automatic t_mu();
    for (int k = 0; k < 2; k++) begin
      lerr <= k[0];
      mu <= k[0] ? 8'hA3 : 8'h5C;
      ctl_in <= '{valid: 1'b1, last: 1'b0, data: 64'h0};
      @(posedge aclk);
      ctl_in.valid <= 1'b0;
      repeat (5) @(posedge aclk);
      chk(rmu === 8'h5C, "rx multi-use");
    end
    lerr <= 1'b0;
    $display("test multi-use done");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_lim();
    t_off();
    t_diag();
    t_mu();
    end_of_test();
  end
endmodule
